// ---- ccm_regs.vh ----
// register map, field layout, mode codes and parameters for the capture/compare/pwm channel
//
// Function
// - mode 0000 switches channel off and clears its pin, prescaler and pwm state; event flag and capture value hold.
// - mode 0010 toggles the output pin on each compare match.
// - mode 0100 captures on falling edges, 0101 on rising edges.
// - mode 0110 captures every fourth rising edge, 0111 every sixteenth.
// - mode 1000 drives pin high on match and sets event flag.
// - mode 1001 drives pin low on match and sets event flag.
// - mode 1010 sets event flag on match only, pin unchanged.
// - mode 1011 sets flag, pin unchanged, resets the assigned timer.
// - fifth channel only: special event trigger also sets converter-on.
// - mode codes 11xx select pwm; output config decides pin usage.
// - duty value is duty high byte then two duty low bits.
// - compare uses output a; capture releases a, and b, c, d are released to port.
// - half-bridge pwm: config 0x modulates a only, 1x a and b.
// - full-bridge config 00 modulates a only; b, c, d port pins.
// - full-bridge config 01 forward: d modulated, a active, b c inactive.
// - full-bridge config 10 modulates a and b; c, d port pins.
// - full-bridge config 11 reverse: b modulated, c active, a d inactive.
// - low mode bits set polarity of a/c pair and b/d pair, one active-low.
// - timer select: 00 first pair, 01 second, 10 third, 11 reserved.
`ifndef CCM_REGS_VH
`define CCM_REGS_VH

// ----------------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------------
`define CCM_ADDR_MODE_CTRL 4'h0
`define CCM_ADDR_DUTY_HIGH 4'h1
`define CCM_ADDR_TIMER_SEL 4'h2
`define CCM_ADDR_STATUS 4'h3
`define CCM_ADDR_CAPTURE 4'h4
`define CCM_ADDR_COMPARE 4'h5

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CCM_MODE_HI 3
`define CCM_MODE_LO 0
`define CCM_DUTY_LO_HI 5
`define CCM_DUTY_LO_LO 4
`define CCM_OCFG_HI 7
`define CCM_OCFG_LO 6
`define CCM_STAT_FLAG 0
`define CCM_STAT_CONV 1

// ----------------------------------------------------------------------------
// mode codes
// ----------------------------------------------------------------------------
`define CCM_M_OFF 4'h0
`define CCM_M_TOGGLE 4'h2
`define CCM_M_CAP_FALL 4'h4
`define CCM_M_CAP_RISE 4'h5
`define CCM_M_CAP_R4 4'h6
`define CCM_M_CAP_R16 4'h7
`define CCM_M_CMP_SET 4'h8
`define CCM_M_CMP_CLR 4'h9
`define CCM_M_CMP_SWI 4'ha
`define CCM_M_CMP_SPEC 4'hb
`define CCM_PWM_SEL 2'h3

// ----------------------------------------------------------------------------
// output configurations, timer pairs, reset values
// ----------------------------------------------------------------------------
`define CCM_OC_SINGLE 2'h0
`define CCM_OC_FWD 2'h1
`define CCM_OC_HALF 2'h2
`define CCM_OC_REV 2'h3
`define CCM_TSEL_RSVD 2'h3
`define CCM_RST_BYTE 8'h00
`define CCM_RST_WORD 16'h0000
`define CCM_PRESC4_LAST 4'h3
`define CCM_PRESC16_LAST 4'hf

`endif

// ---- ccm_channel.v ----
// capture/compare/pwm channel with mode select and enhanced output steering
`timescale 1ns/1ns
`include "ccm_regs.vh"

module ccm_channel #(
    parameter TIMER_W = 16,
    parameter FULL_BRIDGE = 1,
    parameter IS_FIFTH = 0
) (
    input wire i_core_clk,
    input wire i_rst,
    input wire [3:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    input wire [TIMER_W-1:0] i_timer_p1,
    input wire [TIMER_W-1:0] i_timer_p2,
    input wire [TIMER_W-1:0] i_timer_p3,
    input wire [9:0] i_pwm_count,
    input wire i_pwm_period_start,
    input wire i_capture_pin,
    input wire [3:0] i_port_out,
    output reg o_pwm_out_a,
    output reg o_pwm_out_b,
    output reg o_pwm_out_c,
    output reg o_pwm_out_d,
    output reg [3:0] o_pin_oe,
    output reg o_channel_event_flag,
    output reg [2:0] o_assigned_timer_reset,
    output reg o_converter_on
);

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    reg [7:0] ctrl_q;
    reg [7:0] duty_high_byte_q;
    reg [1:0] timer_pair_select_q;
    reg [TIMER_W-1:0] compare_q;
    reg [TIMER_W-1:0] capture_q;
    reg flag_q;
    reg conv_q;
    reg cmp_pin_q;
    reg [2:0] cap_sync_q;
    reg cap_prev_q;
    reg [3:0] presc_q;
    reg [9:0] duty_act_q;
    reg pwm_level_q;
    reg match_prev_q;

    wire [3:0] channel_mode_select = ctrl_q[`CCM_MODE_HI:`CCM_MODE_LO];
    wire [1:0] duty_low_bits = ctrl_q[`CCM_DUTY_LO_HI:`CCM_DUTY_LO_LO];
    wire [1:0] output_config_select = ctrl_q[`CCM_OCFG_HI:`CCM_OCFG_LO];
    wire pwm_mode = (channel_mode_select[3:2] == `CCM_PWM_SEL);
    wire is_cmp = (channel_mode_select == `CCM_M_TOGGLE) || channel_mode_select[3:2] == 2'h2;

    function [TIMER_W-1:0] pick_timer;
        input [1:0] sel;
        input [TIMER_W-1:0] t1;
        input [TIMER_W-1:0] t2;
        input [TIMER_W-1:0] t3;
        begin
            case (sel)
                2'h0: pick_timer = t1;
                2'h1: pick_timer = t2;
                2'h2: pick_timer = t3;
                default: pick_timer = t1;
            endcase
        end
    endfunction

    wire [TIMER_W-1:0] assigned_timer = pick_timer(timer_pair_select_q, i_timer_p1, i_timer_p2, i_timer_p3);
    wire match_now = is_cmp && (assigned_timer == compare_q);
    // only the first cycle of a match counts, since the timer may hold its value
    wire match_ev = match_now && !match_prev_q;

    // ------------------------------------------------------------------------
    // capture edge detect; sync stage 0 is seen only by stage 1
    // ------------------------------------------------------------------------
    wire cap_level = cap_sync_q[1] == cap_sync_q[2] ? cap_sync_q[2] : cap_prev_q;
    wire rise_ev = cap_level && !cap_prev_q;
    wire fall_ev = !cap_level && cap_prev_q;
    reg cap_take;

    always @* begin
        case (channel_mode_select)
            `CCM_M_CAP_FALL: cap_take = fall_ev;
            `CCM_M_CAP_RISE: cap_take = rise_ev;
            `CCM_M_CAP_R4: cap_take = rise_ev && presc_q == `CCM_PRESC4_LAST;
            `CCM_M_CAP_R16: cap_take = rise_ev && presc_q == `CCM_PRESC16_LAST;
            default: cap_take = 1'b0;
        endcase
    end

    wire flag_set = cap_take || (match_ev && channel_mode_select[3]);
    wire flag_clr = i_wr && i_addr == `CCM_ADDR_STATUS && i_wdata[`CCM_STAT_FLAG];
    wire conv_clr = i_wr && i_addr == `CCM_ADDR_STATUS && i_wdata[`CCM_STAT_CONV];
    wire spec_ev = match_ev && channel_mode_select == `CCM_M_CMP_SPEC;

    // ------------------------------------------------------------------------
    // register writes and channel state
    // ------------------------------------------------------------------------
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            ctrl_q <= `CCM_RST_BYTE;
            duty_high_byte_q <= `CCM_RST_BYTE;
            timer_pair_select_q <= 2'h0;
            compare_q <= {TIMER_W{1'b0}};
            capture_q <= {TIMER_W{1'b0}};
            flag_q <= 1'b0;
            conv_q <= 1'b0;
            cmp_pin_q <= 1'b0;
            cap_sync_q <= 3'h0;
            cap_prev_q <= 1'b0;
            presc_q <= 4'h0;
            duty_act_q <= 10'h000;
            pwm_level_q <= 1'b0;
            match_prev_q <= 1'b0;
        end else begin
            cap_sync_q <= {cap_sync_q[1:0], i_capture_pin};
            cap_prev_q <= cap_level;
            match_prev_q <= match_now;
            if (i_wr && i_addr == `CCM_ADDR_MODE_CTRL) begin
                ctrl_q <= i_wdata;
            end
            if (i_wr && i_addr == `CCM_ADDR_DUTY_HIGH) begin
                duty_high_byte_q <= i_wdata;
            end
            if (i_wr && i_addr == `CCM_ADDR_TIMER_SEL && i_wdata[1:0] != `CCM_TSEL_RSVD) begin
                timer_pair_select_q <= i_wdata[1:0];
            end
            if (i_wr && i_addr == `CCM_ADDR_COMPARE) begin
                compare_q <= {{(TIMER_W-8){1'b0}}, i_wdata};
            end
            // hardware set wins over a software clear in the same cycle
            if (flag_set) begin
                flag_q <= 1'b1;
            end else if (flag_clr) begin
                flag_q <= 1'b0;
            end
            if (IS_FIFTH != 0 && spec_ev) begin
                conv_q <= 1'b1;
            end else if (conv_clr) begin
                conv_q <= 1'b0;
            end
            if (channel_mode_select == `CCM_M_OFF) begin
                cmp_pin_q <= 1'b0;
                presc_q <= 4'h0;
                duty_act_q <= 10'h000;
                pwm_level_q <= 1'b0;
            end else begin
                if (match_ev) begin
                    case (channel_mode_select)
                        `CCM_M_TOGGLE: cmp_pin_q <= !cmp_pin_q;
                        `CCM_M_CMP_SET: cmp_pin_q <= 1'b1;
                        `CCM_M_CMP_CLR: cmp_pin_q <= 1'b0;
                        default: cmp_pin_q <= cmp_pin_q;
                    endcase
                end
                if (rise_ev) begin
                    presc_q <= (channel_mode_select == `CCM_M_CAP_R4 && presc_q == `CCM_PRESC4_LAST) ? 4'h0
                        : presc_q + 4'h1;
                end
                if (cap_take) begin
                    capture_q <= assigned_timer;
                end
                // duty reloads at period start so a period is never torn
                if (i_pwm_period_start) begin
                    duty_act_q <= {duty_high_byte_q, duty_low_bits};
                    pwm_level_q <= pwm_mode && {duty_high_byte_q, duty_low_bits} != 10'h000;
                end else if (i_pwm_count >= duty_act_q) begin
                    pwm_level_q <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // output steering; outputs registered
    // ------------------------------------------------------------------------
    reg [3:0] act;
    reg [3:0] use_pin;
    wire pol_ac = channel_mode_select[1];
    wire pol_bd = channel_mode_select[0];

    always @* begin
        act = 4'h0;
        use_pin = 4'h0;
        if (pwm_mode) begin
            if (!FULL_BRIDGE) begin
                if (!output_config_select[1]) begin
                    act = {3'h0, pwm_level_q};
                    use_pin = 4'h1;
                end else begin
                    act = {2'h0, !pwm_level_q, pwm_level_q};
                    use_pin = 4'h3;
                end
            end else begin
                case (output_config_select)
                    `CCM_OC_SINGLE: begin
                        act = {3'h0, pwm_level_q};
                        use_pin = 4'h1;
                    end
                    `CCM_OC_FWD: begin
                        act = {pwm_level_q, 3'h1};
                        use_pin = 4'hf;
                    end
                    `CCM_OC_HALF: begin
                        act = {2'h0, !pwm_level_q, pwm_level_q};
                        use_pin = 4'h3;
                    end
                    default: begin
                        act = {2'h1, pwm_level_q, 1'b0};
                        use_pin = 4'hf;
                    end
                endcase
            end
        end else if (channel_mode_select != `CCM_M_OFF) begin
            act = {3'h0, cmp_pin_q};
            use_pin = {3'h0, is_cmp};
        end
    end

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            o_pwm_out_a <= 1'b0;
            o_pwm_out_b <= 1'b0;
            o_pwm_out_c <= 1'b0;
            o_pwm_out_d <= 1'b0;
            o_pin_oe <= 4'h0;
            o_channel_event_flag <= 1'b0;
            o_assigned_timer_reset <= 3'h0;
            o_converter_on <= 1'b0;
            o_rdata <= `CCM_RST_BYTE;
        end else begin
            o_pwm_out_a <= use_pin[0] ? (pwm_mode ? act[0] ^ pol_ac : act[0]) : i_port_out[0];
            o_pwm_out_b <= use_pin[1] ? act[1] ^ pol_bd : i_port_out[1];
            o_pwm_out_c <= use_pin[2] ? act[2] ^ pol_ac : i_port_out[2];
            o_pwm_out_d <= use_pin[3] ? act[3] ^ pol_bd : i_port_out[3];
            o_pin_oe <= use_pin;
            o_channel_event_flag <= flag_q;
            o_assigned_timer_reset <= spec_ev ? (3'h1 << timer_pair_select_q) : 3'h0;
            o_converter_on <= conv_q;
            o_rdata <= `CCM_RST_BYTE;
            if (i_rd) begin
                case (i_addr)
                    `CCM_ADDR_MODE_CTRL: o_rdata <= ctrl_q;
                    `CCM_ADDR_DUTY_HIGH: o_rdata <= duty_high_byte_q;
                    `CCM_ADDR_TIMER_SEL: o_rdata <= {6'h00, timer_pair_select_q};
                    `CCM_ADDR_STATUS: o_rdata <= {6'h00, conv_q, flag_q};
                    `CCM_ADDR_CAPTURE: o_rdata <= capture_q[7:0];
                    `CCM_ADDR_COMPARE: o_rdata <= compare_q[7:0];
                    default: o_rdata <= `CCM_RST_BYTE;
                endcase
            end
        end
    end

endmodule

// ---- ccm_channel_asserts.sv ----
// concurrent checks on the capture/compare/pwm channel ports
`timescale 1ns/1ns
module ccm_channel_chk #(
    parameter TIMER_W = 16,
    parameter FULL_BRIDGE = 1,
    parameter IS_FIFTH = 0
) (
    input wire i_core_clk,
    input wire i_rst,
    input wire [3:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire o_pwm_out_a,
    input wire o_pwm_out_b,
    input wire o_pwm_out_c,
    input wire o_pwm_out_d,
    input wire [3:0] o_pin_oe,
    input wire o_channel_event_flag,
    input wire [2:0] o_assigned_timer_reset,
    input wire o_converter_on
);
    // ------------------------------------------------------------------
    // shadow of the mode control byte
    // ------------------------------------------------------------------
    reg [7:0] ctl_q;
    reg [1:0] age_q;
    // pins are judged only once a mode write has had time to reach them
    wire settled = age_q == 2'h3;
    wire pwm = ctl_q[3:2] == 2'h3;
    wire clr = i_wr && i_addr == 4'h3 && i_wdata[0];
    wire offw = i_wr && i_addr == 4'h0 && i_wdata[3:0] == 4'h0;
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            ctl_q <= 8'h00;
            age_q <= 2'h0;
        end else if (i_wr && i_addr == 4'h0) begin
            ctl_q <= i_wdata;
            age_q <= 2'h0;
        end else if (age_q != 2'h3) begin
            age_q <= age_q + 2'h1;
        end
    end
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    off_quiet_a: assert property (
        settled && ctl_q[3:0] == 4'h0 |-> o_assigned_timer_reset == 3'h0 && !$rose(o_channel_event_flag))
        else $error("channel off yet active");
    rsvd_quiet_a: assert property (
        settled && (ctl_q[3:0] == 4'h1 || ctl_q[3:0] == 4'h3) |-> !$rose(o_channel_event_flag))
        else $error("reserved mode raised the flag");
    flag_hold_a: assert property (
        $fell(o_channel_event_flag) |-> $past(clr) || $past(clr, 2) || $past(offw) || $past(offw, 2) || $past(i_rst))
        else $error("event flag dropped without a clear");
    swi_pin_a: assert property (
        settled && ctl_q[3:1] == 3'h5 |-> $stable(o_pwm_out_a))
        else $error("pin moved in a flag-only compare mode");
    capcmp_release_a: assert property (
        settled && !pwm |-> o_pin_oe[3:1] == 3'h0)
        else $error("b, c or d driven outside pwm");
    single_pins_a: assert property (
        settled && pwm && ctl_q[7:6] == 2'h0 |-> o_pin_oe == 4'h1)
        else $error("single output drives wrong pins");
    half_pins_a: assert property (
        settled && pwm && ctl_q[7:6] == 2'h2 |-> o_pin_oe == 4'h3)
        else $error("half bridge drives wrong pins");
    hb_pins_a: assert property (
        FULL_BRIDGE == 0 && settled && pwm |-> o_pin_oe == (ctl_q[7] ? 4'h3 : 4'h1))
        else $error("half-bridge build drives wrong pins");
    fwd_drive_a: assert property (
        FULL_BRIDGE != 0 && settled && pwm && ctl_q[7:6] == 2'h1 |-> o_pin_oe == 4'hf && o_pwm_out_a == !ctl_q[1]
            && o_pwm_out_b == ctl_q[0] && o_pwm_out_c == ctl_q[1])
        else $error("forward drive levels wrong");
    rev_drive_a: assert property (
        FULL_BRIDGE != 0 && settled && pwm && ctl_q[7:6] == 2'h3 |-> o_pin_oe == 4'hf && o_pwm_out_c == !ctl_q[1]
            && o_pwm_out_a == ctl_q[1] && o_pwm_out_d == ctl_q[0])
        else $error("reverse drive levels wrong");
    tmr_pulse_a: assert property (
        o_assigned_timer_reset != 3'h0 |-> $onehot(o_assigned_timer_reset) ##1 o_assigned_timer_reset == 3'h0)
        else $error("timer reset not a one-hot single pulse");
    conv_event_a: assert property (
        $rose(o_converter_on) |-> IS_FIFTH != 0 && ($past(o_assigned_timer_reset) != 3'h0
            || o_assigned_timer_reset != 3'h0 || $past(o_assigned_timer_reset, 2) != 3'h0))
        else $error("converter on without special event");
endmodule
bind ccm_channel ccm_channel_chk #(.TIMER_W(TIMER_W), .FULL_BRIDGE(FULL_BRIDGE), .IS_FIFTH(IS_FIFTH)) chk_i (
    .i_core_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .o_pwm_out_a, .o_pwm_out_b, .o_pwm_out_c, .o_pwm_out_d,
    .o_pin_oe, .o_channel_event_flag, .o_assigned_timer_reset, .o_converter_on);

// ---- ccm_pin_model.sv ----
// capture pin source and general port lines outside the channel
`timescale 1ns/1ns
module ccm_pin_model (
    input wire i_core_clk,
    output reg o_pin,
    output reg [3:0] o_port
);
    initial o_pin = 1'b0;
    initial o_port = 4'h5;
    // port lines never hold still, so a pin wrongly showing them is seen
    always @(posedge i_core_clk) o_port <= ~o_port;
    // each edge is held long enough to pass the input synchroniser
    task edges(input integer n);
        begin
            repeat (n) begin
                @(posedge i_core_clk);
                o_pin <= ~o_pin;
                repeat (6) @(posedge i_core_clk);
            end
        end
    endtask
endmodule

// ---- ccm_channel_tb_top.sv ----
// self-checking bench for the capture/compare/pwm channel
`timescale 1ns/1ns
module ccm_channel_tb_top;
    reg i_core_clk = 1'b0;
    reg i_rst = 1'b1;
    reg i_wr = 1'b0;
    reg i_rd = 1'b0;
    reg i_pwm_period_start = 1'b0;
    reg [3:0] i_addr = 4'h0;
    reg [7:0] i_wdata = 8'h00;
    reg [15:0] i_timer_p1 = 16'h0000;
    reg [15:0] i_timer_p2 = 16'h0000;
    reg [15:0] i_timer_p3 = 16'h0000;
    reg [9:0] i_pwm_count = 10'h3ff;
    wire i_capture_pin;
    wire [3:0] i_port_out;
    wire [7:0] o_rdata;
    wire o_pwm_out_a, o_pwm_out_b, o_pwm_out_c, o_pwm_out_d, o_channel_event_flag, o_converter_on;
    wire [3:0] o_pin_oe;
    wire [2:0] o_assigned_timer_reset;
    wire [3:0] hb_oe;
    wire [3:0] pins = {o_pwm_out_d, o_pwm_out_c, o_pwm_out_b, o_pwm_out_a};
    integer fail_count = 0;
    integer comparisons = 0;
    integer i;
    reg [2:0] tr_seen;
    ccm_channel #(.IS_FIFTH(1)) ccm_channel_i (.i_core_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_timer_p1, .i_timer_p2, .i_timer_p3, .i_pwm_count, .i_pwm_period_start, .i_capture_pin, .i_port_out,
        .o_pwm_out_a, .o_pwm_out_b, .o_pwm_out_c, .o_pwm_out_d, .o_pin_oe, .o_channel_event_flag,
        .o_assigned_timer_reset, .o_converter_on);
    ccm_pin_model ccm_pin_model_i (.i_core_clk(i_core_clk), .o_pin(i_capture_pin), .o_port(i_port_out));
    // half-bridge build shares the bus and pins; only its pin enables are judged
    ccm_channel #(.FULL_BRIDGE(0)) ccm_channel_hb_i (.i_core_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
        .o_rdata(), .i_timer_p1, .i_timer_p2, .i_timer_p3, .i_pwm_count, .i_pwm_period_start, .i_capture_pin,
        .i_port_out, .o_pwm_out_a(), .o_pwm_out_b(), .o_pwm_out_c(), .o_pwm_out_d(), .o_pin_oe(hb_oe),
        .o_channel_event_flag(), .o_assigned_timer_reset(), .o_converter_on());
    initial forever #5 i_core_clk = ~i_core_clk;
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge i_core_clk);
            i_addr <= a;
            i_wdata <= d;
            i_wr <= 1'b1;
            @(posedge i_core_clk);
            i_wr <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, input [7:0] exp);
        begin
            @(posedge i_core_clk);
            i_addr <= a;
            i_rd <= 1'b1;
            @(posedge i_core_clk);
            i_rd <= 1'b0;
            #1 chk(o_rdata, exp);
        end
    endtask
    // one compare match on the second timer pair, collecting timer resets
    task hit;
        begin
            tr_seen = 3'h0;
            @(posedge i_core_clk);
            i_timer_p2 <= 16'h0010;
            @(posedge i_core_clk);
            i_timer_p2 <= 16'h0000;
            // the reset pulse stands only in the cycle right after the match edge
            #1 tr_seen = o_assigned_timer_reset;
            repeat (5) begin
                @(posedge i_core_clk);
                #1 tr_seen = tr_seen | o_assigned_timer_reset;
            end
        end
    endtask
    task period(input [1:0] s, input integer exp);
        integer k, h;
        begin
            h = 0;
            for (k = 0; k < 28; k = k + 1) begin
                @(posedge i_core_clk);
                i_pwm_count <= (k < 16) ? k[9:0] : 10'h3ff;
                i_pwm_period_start <= (k == 0);
                #1 h = h + pins[s];
            end
            chk(h[15:0], exp[15:0]);
        end
    endtask
    task conclude;
        begin
            $display("mismatches %0d comparisons %0d", fail_count, comparisons);
            if (fail_count == 0 && comparisons > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task t_regs;
        begin
            for (i = 0; i < 5; i = i + 1) rd(i[3:0], 8'h00);
            rd(4'hf, 8'h00);
            wr(4'h1, 8'h02);
            rd(4'h1, 8'h02);
            wr(4'h2, 8'h01);
            wr(4'h2, 8'h03);
            rd(4'h2, 8'h01);
        end
    endtask
    task t_compare;
        reg [3:0] m;
        reg [19:0] ms;
        reg [4:0] pe;
        begin
            ms = 20'h892ab;
            pe = 5'b11101;
            wr(4'h5, 8'h10);
            for (i = 0; i < 5; i = i + 1) begin
                m = ms[19 - 4 * i -: 4];
                wr(4'h0, {4'h0, m});
                hit;
                chk(o_pwm_out_a, pe[i]);
                chk({o_converter_on, o_channel_event_flag}, (i == 4) ? 2'h3 : {1'b0, m[3]});
                if (m != 4'h2) rd(4'h3, (i == 4) ? 8'h03 : 8'h01);
                chk(tr_seen, (i == 4) ? 3'h2 : 3'h0);
                wr(4'h3, 8'h03);
            end
            wr(4'h0, 8'h00);
            wr(4'h0, 8'h08);
            repeat (3) @(posedge i_core_clk);
            #1 chk(o_pwm_out_a, 1'b0);
            for (i = 1; i < 4; i = i + 2) begin
                wr(4'h0, i[7:0]);
                hit;
                rd(4'h3, 8'h00);
            end
        end
    endtask
    task t_capture;
        begin
            wr(4'h0, 8'h04);
            i_timer_p2 <= 16'h0022;
            ccm_pin_model_i.edges(1);
            rd(4'h3, 8'h00);
            @(posedge i_core_clk) i_timer_p2 <= 16'h0033;
            ccm_pin_model_i.edges(1);
            rd(4'h4, 8'h33);
            wr(4'h3, 8'h01);
            wr(4'h0, 8'h05);
            i_timer_p2 <= 16'h0055;
            ccm_pin_model_i.edges(1);
            rd(4'h3, 8'h01);
            rd(4'h4, 8'h55);
            for (i = 6; i < 8; i = i + 1) begin
                wr(4'h0, 8'h00);
                wr(4'h3, 8'h01);
                wr(4'h0, i[7:0]);
                ccm_pin_model_i.edges((i == 6) ? 6 : 30);
                rd(4'h3, 8'h00);
                ccm_pin_model_i.edges(2);
                rd(4'h3, 8'h01);
            end
        end
    endtask
    task t_pwm;
        reg [47:0] cw;
        reg [11:0] sw;
        reg [5:0] ew;
        begin
            // duty 9 of 28 samples: active-high pins count 9, active-low or complement pins 19
            cw = 48'h1c1e9c5cdc5d;
            sw = 12'h077;
            ew = 6'b011001;
            @(posedge i_core_clk) i_timer_p2 <= 16'h0000;
            for (i = 0; i < 6; i = i + 1) begin
                wr(4'h0, cw[47 - 8 * i -: 8]);
                repeat (4) @(posedge i_core_clk);
                period(sw[11 - 2 * i -: 2], ew[5 - i] ? 19 : 9);
                chk(hb_oe, cw[47 - 8 * i] ? 4'h3 : 4'h1);
            end
            @(posedge i_core_clk);
            i_rst <= 1'b1;
            @(posedge i_core_clk);
            i_rst <= 1'b0;
            rd(4'h0, 8'h00);
            chk(o_pin_oe, 4'h0);
        end
    endtask
    initial begin
        repeat (3) @(posedge i_core_clk);
        i_rst <= 1'b0;
        t_regs;
        t_compare;
        t_capture;
        t_pwm;
        conclude;
    end
    initial begin
        #100000;
        fail_count = fail_count + 1;
        conclude;
    end
endmodule
